/* src/param_bank.sv */
// Purpose: register bank holding the sensor's parameter set
// Assumes: index-addressed register port, read data one cycle later
// Notes:   measured values are sampled from inputs on read
//
// What this block does
// RQ1: node address 8-bit RW, default 25, factory-restored
// RQ2: bit rate 16-bit read-only, default 250
// RQ3: writing 1 resets the processor core
// RQ4: quadrant correction: off, plus-minus 180, 0-360
// RQ5: teach: no change, capture relative, clear absolute
// RQ6: angle filter off or four low-pass cut-offs
// RQ7: angle method: perpendicular, Euler, two gimbal orders
// RQ8: termination resistor switch: 0 off, 1 on
// RQ9: zero set: no change, capture relative, cancel
// RQ10: output select: angles, vibration, accel without/with DC
// RQ11: accel with DC forces 2 g range
// RQ12: axis enable bits: X bit2, Y bit1, Z bit0
// RQ13: vibration filter off or five band-pass codes
// RQ14: measuring range: 2 g, 4 g, 8 g
// RQ15: writing 1 restores factory defaults
// RQ16: temperatures signed tenths, heater power milliwatts
// RQ17: angles readable as 16 and 32 bit
// RQ18: velocity, peak and axis accelerations readable
// RQ19: new address, rate active only after reset
// RQ20: zero set latches offset, subtracted from angles
// RQ21: undefined enumerated codes rejected, old kept
module param_bank
   import param_bank_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   input  wire logic        app_reset,
   input  wire logic [15:0] ambient_temp,
   input  wire logic [15:0] element_temp,
   input  wire logic [15:0] heater_power,
   input  wire logic [31:0] raw_long,
   input  wire logic [31:0] raw_lat,
   input  wire logic [31:0] velocity_rms,
   input  wire logic [31:0] peak_accel,
   input  wire logic [15:0] acc_x,
   input  wire logic [15:0] acc_y,
   input  wire logic [15:0] acc_z,
   output logic      [7:0]  active_node_addr,
   output logic      [15:0] active_bit_rate,
   output logic             core_reset,
   output logic      [1:0]  quadrant_mode,
   output logic             heater_on,
   output logic             teach_relative,
   output logic             teach_capture,
   output logic      [2:0]  angle_filter,
   output logic      [1:0]  angle_method,
   output logic             termination_on,
   output logic             zero_relative,
   output logic      [1:0]  output_select,
   output logic      [2:0]  axis_enable,
   output logic      [2:0]  vib_filter,
   output logic      [1:0]  meas_range,
   output logic      [31:0] angle_long,
   output logic      [31:0] angle_lat,
   output logic      [31:0] zero_off_long,
   output logic      [31:0] zero_off_lat
);
   // -----------------------------------------------------------------
   // stored settings
   // -----------------------------------------------------------------
   logic [7:0]  node_addr_ff;    // programmed address
   logic [7:0]  act_addr_ff;     // address in use
   logic [15:0] act_rate_ff;     // bit rate in use
   logic        core_rst_ff;     // one-cycle core reset pulse
   logic [7:0]  quad_ff;         // quadrant correction
   logic [7:0]  heat_ff;         // heater flag
   logic [7:0]  teach_ff;        // last teach command
   logic        teach_rel_ff;    // relative teach state
   logic        teach_cap_ff;    // teach capture pulse
   logic [7:0]  afilt_ff;        // angle filter
   logic [7:0]  amethod_ff;      // angle method
   logic [7:0]  term_ff;         // termination
   logic [7:0]  zero_ff;         // last zero command
   logic        zero_rel_ff;     // zero active
   logic [31:0] zoff_long_ff;    // stored longitudinal offset
   logic [31:0] zoff_lat_ff;     // stored lateral offset
   logic [7:0]  outsel_ff;       // output quantity
   logic [7:0]  axis_ff;         // vibration axes
   logic [7:0]  vfilt_ff;        // vibration filter
   logic [7:0]  range_ff;        // measuring range
   logic [31:0] ang_long_ff;     // corrected angle
   logic [31:0] ang_lat_ff;      // corrected angle
   logic [31:0] rdata_ff;        // read data register
   logic [7:0]  wb;              // low write byte
   logic        factory;         // factory restore request
   logic        wr_ok_8;         // helper: any write that is not a factory restore

   assign wb      = wdata[7:0];
   assign factory = wr && addr == IDX_FACTORY && wb == CMD_SET; // [RQ15]

   // -----------------------------------------------------------------
   // communication settings
   // -----------------------------------------------------------------
   // address stored now, copied to the active set only on a reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         node_addr_ff <= RST_NODE_ADDR;
      end else if (factory) begin
         node_addr_ff <= RST_NODE_ADDR; // [RQ1]
      end else if (wr && addr == IDX_NODE_ADDR) begin
         node_addr_ff <= wb; // [RQ1]
      end
   end

   // active address and rate follow reset events only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         act_addr_ff <= RST_NODE_ADDR;
         act_rate_ff <= RST_BIT_RATE; // [RQ2]
      end else if (app_reset || core_rst_ff) begin
         act_addr_ff <= node_addr_ff; // [RQ19]
         act_rate_ff <= RST_BIT_RATE;
      end
   end

   // processor core reset pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_rst_ff <= 1'b0;
      end else begin
         core_rst_ff <= wr && addr == IDX_PROC_RESET && wb == CMD_SET; // [RQ3]
      end
   end

   // -----------------------------------------------------------------
   // enumerated selections, undefined codes dropped
   // -----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         quad_ff    <= RST_SEL;
         heat_ff    <= RST_SEL;
         afilt_ff   <= RST_SEL;
         amethod_ff <= RST_SEL;
         term_ff    <= RST_SEL;
         outsel_ff  <= RST_SEL;
         axis_ff    <= RST_AXIS_EN;
         vfilt_ff   <= RST_SEL;
         range_ff   <= RST_SEL;
      end else if (factory) begin
         quad_ff    <= RST_SEL; // [RQ15]
         heat_ff    <= RST_SEL;
         afilt_ff   <= RST_SEL;
         amethod_ff <= RST_SEL;
         term_ff    <= RST_SEL;
         outsel_ff  <= RST_SEL;
         axis_ff    <= RST_AXIS_EN;
         vfilt_ff   <= RST_SEL;
         range_ff   <= RST_SEL;
      end else if (wr) begin
         case (addr)
            IDX_QUADRANT:   if (wb <= MAX_QUADRANT)   quad_ff    <= wb; // [RQ4] [RQ21]
            IDX_HEATER:     if (wb <= MAX_ON_OFF)     heat_ff    <= wb; // [RQ21]
            IDX_ANG_FILT:   if (wb <= MAX_ANG_FILT)   afilt_ff   <= wb; // [RQ6] [RQ21]
            IDX_ANG_METHOD: if (wb <= MAX_ANG_METHOD) amethod_ff <= wb; // [RQ7] [RQ21]
            IDX_TERM:       if (wb <= MAX_ON_OFF)     term_ff    <= wb; // [RQ8] [RQ21]
            IDX_OUT_SEL: begin
               if (wb <= MAX_OUT_SEL) begin
                  outsel_ff <= wb; // [RQ10] [RQ21]
                  if (wb == OUT_ACC_DC) begin
                     range_ff <= RANGE_2G; // [RQ11]
                  end
               end
            end
            IDX_AXIS_EN:    if (wb <= MAX_AXIS_EN)    axis_ff    <= wb; // [RQ12] [RQ21]
            IDX_VIB_FILT:   if (wb <= MAX_VIB_FILT)   vfilt_ff   <= wb; // [RQ13] [RQ21]
            IDX_RANGE: begin
               // range held at 2 g while accel with DC is selected
               if (wb <= MAX_RANGE && outsel_ff != OUT_ACC_DC) begin
                  range_ff <= wb; // [RQ14] [RQ11] [RQ21]
               end
            end
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // teach command
   // -----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         teach_ff     <= RST_SEL;
         teach_rel_ff <= 1'b0;
         teach_cap_ff <= 1'b0;
      end else begin
         teach_cap_ff <= 1'b0;
         if (factory) begin
            teach_ff     <= RST_SEL;
            teach_rel_ff <= 1'b0;
         end else if (wr && addr == IDX_TEACH && wb <= MAX_TEACH) begin
            teach_ff <= wb; // [RQ21]
            if (wb == CMD_SET) begin
               teach_rel_ff <= 1'b1; // [RQ5]
               teach_cap_ff <= 1'b1;
            end else if (wb == CMD_CLEAR) begin
               teach_rel_ff <= 1'b0; // [RQ5]
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // zero point: offset captured and subtracted
   // -----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zero_ff      <= RST_SEL;
         zero_rel_ff  <= 1'b0;
         zoff_long_ff <= 32'h0000_0000;
         zoff_lat_ff  <= 32'h0000_0000;
      end else if (factory) begin
         zero_ff      <= RST_SEL;
         zero_rel_ff  <= 1'b0;
         zoff_long_ff <= 32'h0000_0000;
         zoff_lat_ff  <= 32'h0000_0000;
      end else if (wr && addr == IDX_ZERO && wb <= MAX_TEACH) begin
         zero_ff <= wb; // [RQ21]
         if (wb == CMD_SET) begin
            zero_rel_ff  <= 1'b1; // [RQ9]
            zoff_long_ff <= raw_long; // [RQ20]
            zoff_lat_ff  <= raw_lat;
         end else if (wb == CMD_CLEAR) begin
            zero_rel_ff  <= 1'b0; // [RQ9]
            zoff_long_ff <= 32'h0000_0000;
            zoff_lat_ff  <= 32'h0000_0000;
         end
      end
   end

   // corrected angle results
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ang_long_ff <= 32'h0000_0000;
         ang_lat_ff  <= 32'h0000_0000;
      end else begin
         ang_long_ff <= raw_long - zoff_long_ff; // [RQ20]
         ang_lat_ff  <= raw_lat - zoff_lat_ff;
      end
   end

   // -----------------------------------------------------------------
   // read path, one cycle latency
   // -----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            IDX_NODE_ADDR:  rdata_ff <= {24'h000000, node_addr_ff};
            IDX_BIT_RATE:   rdata_ff <= {16'h0000, RST_BIT_RATE}; // [RQ2]
            IDX_PROC_RESET: rdata_ff <= 32'h0000_0000;
            IDX_QUADRANT:   rdata_ff <= {24'h000000, quad_ff};
            IDX_HEATER:     rdata_ff <= {24'h000000, heat_ff};
            IDX_TEACH:      rdata_ff <= {24'h000000, teach_ff};
            IDX_ANG_FILT:   rdata_ff <= {24'h000000, afilt_ff};
            IDX_ANG_METHOD: rdata_ff <= {24'h000000, amethod_ff};
            IDX_TERM:       rdata_ff <= {24'h000000, term_ff};
            IDX_ZERO:       rdata_ff <= {24'h000000, zero_ff};
            IDX_OUT_SEL:    rdata_ff <= {24'h000000, outsel_ff};
            IDX_AXIS_EN:    rdata_ff <= {24'h000000, axis_ff};
            IDX_VIB_FILT:   rdata_ff <= {24'h000000, vfilt_ff};
            IDX_RANGE:      rdata_ff <= {24'h000000, range_ff};
            IDX_FACTORY:    rdata_ff <= 32'h0000_0000;
            // signed values sign-extended
            IDX_AMB_TEMP:   rdata_ff <= {{16{ambient_temp[15]}}, ambient_temp}; // [RQ16]
            IDX_ELEM_TEMP:  rdata_ff <= {{16{element_temp[15]}}, element_temp}; // [RQ16]
            IDX_HEAT_PWR:   rdata_ff <= {16'h0000, heater_power}; // [RQ16]
            IDX_LONG16:     rdata_ff <= {{16{ang_long_ff[15]}}, ang_long_ff[15:0]}; // [RQ17]
            IDX_LAT16:      rdata_ff <= {{16{ang_lat_ff[15]}}, ang_lat_ff[15:0]}; // [RQ17]
            IDX_LONG32:     rdata_ff <= ang_long_ff; // [RQ17]
            IDX_LAT32:      rdata_ff <= ang_lat_ff; // [RQ17]
            IDX_VEL_RMS:    rdata_ff <= velocity_rms; // [RQ18]
            IDX_PEAK_ACC:   rdata_ff <= peak_accel; // [RQ18]
            IDX_ACC_X:      rdata_ff <= {{16{acc_x[15]}}, acc_x}; // [RQ18]
            IDX_ACC_Y:      rdata_ff <= {{16{acc_y[15]}}, acc_y}; // [RQ18]
            IDX_ACC_Z:      rdata_ff <= {{16{acc_z[15]}}, acc_z}; // [RQ18]
            default:        rdata_ff <= 32'h0000_0000; // unmapped reads zero
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   // -----------------------------------------------------------------
   // outputs straight from flip-flops
   // -----------------------------------------------------------------
   assign rdata            = rdata_ff;
   assign active_node_addr = act_addr_ff;
   assign active_bit_rate  = act_rate_ff;
   assign core_reset       = core_rst_ff;
   assign quadrant_mode    = quad_ff[1:0];
   assign heater_on        = heat_ff[0];
   assign teach_relative   = teach_rel_ff;
   assign teach_capture    = teach_cap_ff;
   assign angle_filter     = afilt_ff[2:0];
   assign angle_method     = amethod_ff[1:0];
   assign termination_on   = term_ff[0];
   assign zero_relative    = zero_rel_ff;
   assign output_select    = outsel_ff[1:0];
   assign axis_enable      = {axis_ff[AXIS_X_BIT], axis_ff[AXIS_Y_BIT], axis_ff[AXIS_Z_BIT]};
   assign vib_filter       = vfilt_ff[2:0];
   assign meas_range       = range_ff[1:0];
   assign angle_long       = ang_long_ff;
   assign angle_lat        = ang_lat_ff;
   assign zero_off_long    = zoff_long_ff;
   assign zero_off_lat     = zoff_lat_ff;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   assign wr_ok_8 = wr && !factory;

   // settings restored, fixed rate, reset pulse
   a_addr_factory: assert property (@(posedge clk) disable iff (rst) // [RQ1]
      factory |=> node_addr_ff == RST_NODE_ADDR)
      else $error("node address not restored");
   a_rate_const: assert property (@(posedge clk) disable iff (rst) // [RQ2]
      act_rate_ff == RST_BIT_RATE)
      else $error("bit rate changed");
   a_core_pulse: assert property (@(posedge clk) disable iff (rst) // [RQ3]
      (wr && addr == IDX_PROC_RESET && wb == CMD_SET) |=> core_reset ##1 !core_reset)
      else $error("core reset pulse wrong");
   a_factory_sel: assert property (@(posedge clk) disable iff (rst) // [RQ15]
      factory |=> axis_ff == RST_AXIS_EN && quad_ff == RST_SEL && !teach_rel_ff)
      else $error("settings not restored");

   // refused codes, teach and forced range
   a_quad_reject: assert property (@(posedge clk) disable iff (rst) // [RQ21]
      (wr_ok_8 && addr == IDX_QUADRANT && wb > MAX_QUADRANT) |=> $stable(quad_ff))
      else $error("bad quadrant code accepted");
   a_teach_set: assert property (@(posedge clk) disable iff (rst) // [RQ5]
      (wr_ok_8 && addr == IDX_TEACH && wb == CMD_SET) |=> teach_relative && teach_capture)
      else $error("teach not captured");
   a_dc_range: assert property (@(posedge clk) disable iff (rst) // [RQ11]
      (wr_ok_8 && addr == IDX_OUT_SEL && wb == OUT_ACC_DC) |=> meas_range == 2'b00)
      else $error("range not forced to 2 g");
   a_range_held: assert property (@(posedge clk) disable iff (rst) // [RQ11]
      outsel_ff == OUT_ACC_DC |-> range_ff == RANGE_2G)
      else $error("range left 2 g");

   // deferred address, zero point, live reads
   a_addr_deferred: assert property (@(posedge clk) disable iff (rst) // [RQ19]
      (!app_reset && !core_rst_ff) |=> $stable(act_addr_ff))
      else $error("address changed without reset");
   a_zero_sub: assert property (@(posedge clk) disable iff (rst) // [RQ20]
      (wr_ok_8 && addr == IDX_ZERO && wb == CMD_SET) ##1 $stable(raw_long)
      |=> angle_long == 32'h0000_0000)
      else $error("zero offset not applied");
   a_zero_clear: assert property (@(posedge clk) disable iff (rst) // [RQ9]
      (wr_ok_8 && addr == IDX_ZERO && wb == CMD_CLEAR)
      |=> !zero_rel_ff && zoff_long_ff == 32'h0000_0000)
      else $error("zero point not cleared");
   a_read_temp: assert property (@(posedge clk) disable iff (rst) // [RQ16]
      (rd && addr == IDX_AMB_TEMP) |=> rdata[15:0] == $past(ambient_temp))
      else $error("temperature read wrong");

   // main scenarios reached
   c_factory:  cover property (@(posedge clk) factory);
   c_dc_sel:   cover property (@(posedge clk) outsel_ff == OUT_ACC_DC);
   c_zero_set: cover property (@(posedge clk) $rose(zero_rel_ff));
   c_reset:    cover property (@(posedge clk) core_rst_ff);
   c_teach:    cover property (@(posedge clk) teach_cap_ff);
endmodule

/* src/param_bank_pkg.sv */
// Purpose: constants for the inclination sensor parameter bank
// Assumes: 16-bit parameter index used as register address
// Notes:   widths fixed; measured values arrive as plain inputs
package param_bank_pkg;
   // -----------------------------------------------------------------
   // parameter indices
   // -----------------------------------------------------------------
   localparam logic [15:0] IDX_NODE_ADDR   = 16'h2000;
   localparam logic [15:0] IDX_BIT_RATE    = 16'h2001;
   localparam logic [15:0] IDX_PROC_RESET  = 16'h2002;
   localparam logic [15:0] IDX_QUADRANT    = 16'h2040;
   localparam logic [15:0] IDX_HEATER      = 16'h2041;
   localparam logic [15:0] IDX_TEACH       = 16'h2042;
   localparam logic [15:0] IDX_ANG_FILT    = 16'h2043;
   localparam logic [15:0] IDX_ANG_METHOD  = 16'h2044;
   localparam logic [15:0] IDX_TERM        = 16'h2045;
   localparam logic [15:0] IDX_ZERO        = 16'h2046;
   localparam logic [15:0] IDX_OUT_SEL     = 16'h2047;
   localparam logic [15:0] IDX_AXIS_EN     = 16'h2048;
   localparam logic [15:0] IDX_VIB_FILT    = 16'h2049;
   localparam logic [15:0] IDX_RANGE       = 16'h204a;
   localparam logic [15:0] IDX_FACTORY     = 16'h207f;
   localparam logic [15:0] IDX_AMB_TEMP    = 16'h2080;
   localparam logic [15:0] IDX_ELEM_TEMP   = 16'h2081;
   localparam logic [15:0] IDX_HEAT_PWR    = 16'h2082;
   localparam logic [15:0] IDX_LONG16      = 16'ha000;
   localparam logic [15:0] IDX_LAT16       = 16'ha001;
   localparam logic [15:0] IDX_LONG32      = 16'ha010;
   localparam logic [15:0] IDX_LAT32       = 16'ha011;
   localparam logic [15:0] IDX_VEL_RMS     = 16'ha100;
   localparam logic [15:0] IDX_PEAK_ACC    = 16'ha101;
   localparam logic [15:0] IDX_ACC_X       = 16'ha200;
   localparam logic [15:0] IDX_ACC_Y       = 16'ha201;
   localparam logic [15:0] IDX_ACC_Z       = 16'ha202;
   // -----------------------------------------------------------------
   // reset / factory values
   // -----------------------------------------------------------------
   localparam logic [7:0]  RST_NODE_ADDR   = 8'h19;    // 25
   localparam logic [15:0] RST_BIT_RATE    = 16'h00fa; // 250 kbit/s
   localparam logic [7:0]  RST_SEL         = 8'h00;
   localparam logic [7:0]  RST_AXIS_EN     = 8'h07;
   // -----------------------------------------------------------------
   // field limits and codes
   // -----------------------------------------------------------------
   localparam logic [7:0]  MAX_QUADRANT    = 8'h02;
   localparam logic [7:0]  MAX_ON_OFF      = 8'h01;
   localparam logic [7:0]  MAX_TEACH       = 8'h02;
   localparam logic [7:0]  MAX_ANG_FILT    = 8'h04;
   localparam logic [7:0]  MAX_ANG_METHOD  = 8'h03;
   localparam logic [7:0]  MAX_OUT_SEL     = 8'h03;
   localparam logic [7:0]  MAX_VIB_FILT    = 8'h05;
   localparam logic [7:0]  MAX_RANGE       = 8'h02;
   localparam logic [7:0]  MAX_AXIS_EN     = 8'h07;
   localparam logic [7:0]  CMD_SET         = 8'h01;
   localparam logic [7:0]  CMD_CLEAR       = 8'h02;
   localparam logic [7:0]  OUT_ACC_DC      = 8'h03;
   localparam logic [7:0]  RANGE_2G        = 8'h00;
   localparam int          AXIS_X_BIT      = 2;
   localparam int          AXIS_Y_BIT      = 1;
   localparam int          AXIS_Z_BIT      = 0;
endpackage

/* tb/host_master_model.sv */
// Purpose: host side of the parameter port, issuing single writes and reads
// Assumes: read data stands only in the cycle after the read strobe
// Notes:   write data is scrambled once the host lets go of the bus
module host_master_model (
   input  wire logic        clk,
   output logic      [15:0] addr,
   output logic      [31:0] wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [31:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------
   initial begin
      addr  = 16'h0000;
      wdata = 32'h0000_0000;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   // one-cycle write strobe beside address and data
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      wdata <= ~d; // released data shows no stale value
   endtask
   // one-cycle read strobe, data taken in the following cycle only
   task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
endmodule

/* tb/param_bank_tb_top.sv */
// Purpose: self-checking bench for the sensor parameter bank
// Assumes: host model drives the register port, bench drives live values
// Notes:   each scenario is a task that drives and judges on its own
module param_bank_tb_top;
   import param_bank_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        clk, rst, wr, rd, app_reset;
   logic [15:0] addr, amb, elt, hpw, ax, ay, az, an, ar;
   logic [31:0] wdata, rdata, rlong, rlat, vel, pk, al, at, zl, zt, d;
   logic [7:0]  nd;
   logic [2:0]  afl, axe, vfl;
   logic [1:0]  qm, am, os, mr;
   logic        crs, hon, trel, tcap, ton, zrel;
   int          err_total, n_checks;
   // ----------------------------------------------------------------
   // instances
   // ----------------------------------------------------------------
   host_master_model host_master_model_inst (.clk(clk), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata));
   param_bank param_bank_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .app_reset(app_reset), .ambient_temp(amb),
      .element_temp(elt), .heater_power(hpw), .raw_long(rlong), .raw_lat(rlat),
      .velocity_rms(vel), .peak_accel(pk), .acc_x(ax), .acc_y(ay), .acc_z(az),
      .active_node_addr(nd), .active_bit_rate(ar), .core_reset(crs),
      .quadrant_mode(qm), .heater_on(hon), .teach_relative(trel),
      .teach_capture(tcap), .angle_filter(afl), .angle_method(am),
      .termination_on(ton), .zero_relative(zrel), .output_select(os),
      .axis_enable(axe), .vib_filter(vfl), .meas_range(mr), .angle_long(al),
      .angle_lat(at), .zero_off_long(zl), .zero_off_lat(zt));
   // clock of 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // checking helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
      host_master_model_inst.rd_reg(a, d);
      chk(d, exp);
   endtask
   task automatic wrap_up();
      if (err_total == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // defaults after reset, unmapped place, read-only place
   task automatic t_defaults();
      rchk(IDX_NODE_ADDR, 32'h0000_0019);
      rchk(IDX_BIT_RATE, 32'h0000_00fa);
      host_master_model_inst.wr_reg(IDX_BIT_RATE, 32'h0000_0064);
      rchk(IDX_BIT_RATE, 32'h0000_00fa);
      rchk(16'h3000, 32'h0000_0000);
      chk({16'h0, ar}, 32'h0000_00fa);
   endtask
   // every code up to the limit kept, the next one refused
   task automatic t_codes();
      logic [15:0] ix [9] = '{IDX_QUADRANT, IDX_HEATER, IDX_ANG_FILT, IDX_ANG_METHOD,
         IDX_TERM, IDX_AXIS_EN, IDX_VIB_FILT, IDX_RANGE, IDX_OUT_SEL};
      logic [7:0]  mx [9] = '{8'h02, 8'h01, 8'h04, 8'h03, 8'h01, 8'h07, 8'h05, 8'h02,
         8'h03};
      for (int i = 0; i < 9; i++) begin
         for (int c = 0; c <= mx[i]; c++) begin
            host_master_model_inst.wr_reg(ix[i], {24'h0, 8'(c)});
            rchk(ix[i], {24'h0, 8'(c)});
         end
         host_master_model_inst.wr_reg(ix[i], {24'h0, mx[i] + 8'h01});
         rchk(ix[i], {24'h0, mx[i]});
      end
      chk({30'h0, os}, 32'h3);
      chk({30'h0, mr}, 32'h0);
      host_master_model_inst.wr_reg(IDX_RANGE, 32'h0000_0001);
      rchk(IDX_RANGE, 32'h0000_0000);
      host_master_model_inst.wr_reg(IDX_OUT_SEL, 32'h0000_0000);
      host_master_model_inst.wr_reg(IDX_AXIS_EN, 32'h0000_0004);
      #1 chk({29'h0, axe}, 32'h4);
      chk({28'h0, ton, hon, qm}, 32'he);
      chk({24'h0, afl, am, vfl}, 32'h9d);
   endtask
   // live values with their signs
   task automatic t_measured();
      rchk(IDX_AMB_TEMP, 32'hffff_ff38);
      rchk(IDX_HEAT_PWR, 32'h0000_0123);
      rchk(IDX_ELEM_TEMP, 32'h0000_00c8);
      rchk(IDX_PEAK_ACC, 32'h0000_0200);
      rchk(IDX_LONG16, 32'h0000_0064);
      rchk(IDX_LAT32, 32'hffff_fff0);
      rchk(IDX_VEL_RMS, 32'h00ab_cdef);
      rchk(IDX_ACC_X, 32'hffff_8001);
   endtask
   // new address waits for a reset of either kind
   task automatic t_address();
      host_master_model_inst.wr_reg(IDX_NODE_ADDR, 32'h0000_0033);
      #1 chk({24'h0, nd}, 32'h19);
      rchk(IDX_NODE_ADDR, 32'h0000_0033);
      host_master_model_inst.wr_reg(IDX_PROC_RESET, 32'h0000_0001);
      #1 chk({31'h0, crs}, 32'h1);
      @(posedge clk);
      #1 chk({23'h0, crs, nd}, 32'h33);
      host_master_model_inst.wr_reg(IDX_NODE_ADDR, 32'h0000_0044);
      app_reset <= 1'b1;
      @(posedge clk);
      app_reset <= 1'b0;
      @(posedge clk);
      #1 chk({24'h0, nd}, 32'h44);
   endtask
   // zero point and teach, then factory defaults
   task automatic t_zero_factory();
      host_master_model_inst.wr_reg(IDX_ZERO, 32'h0000_0001);
      rlong <= 32'h0000_0096;
      repeat (2) @(posedge clk);
      #1 chk(al, 32'h0000_0032);
      chk({31'h0, zrel}, 32'h1);
      host_master_model_inst.wr_reg(IDX_ZERO, 32'h0000_0001);
      repeat (2) @(posedge clk);
      #1 chk(al | at, 32'h0);
      chk(zt, 32'hffff_fff0);
      host_master_model_inst.wr_reg(IDX_TEACH, 32'h0000_0001);
      #1 chk({30'h0, trel, tcap}, 32'h3);
      host_master_model_inst.wr_reg(IDX_FACTORY, 32'h0000_0001);
      rchk(IDX_NODE_ADDR, 32'h0000_0019);
      rchk(IDX_QUADRANT, 32'h0000_0000);
      chk({zrel, trel, axe, zl[26:0]}, {2'b00, 3'b111, 27'h0});
      host_master_model_inst.wr_reg(IDX_TEACH, 32'h0000_0001);
      host_master_model_inst.wr_reg(IDX_ZERO, 32'h0000_0001);
      host_master_model_inst.wr_reg(IDX_TEACH, 32'h0000_0002);
      host_master_model_inst.wr_reg(IDX_ZERO, 32'h0000_0002);
      #1 chk({zrel, trel, zl[29:0]}, 32'h0);
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      err_total = 0;
      n_checks  = 0;
      rst = 1'b1;
      app_reset = 1'b0;
      amb = 16'hff38;
      elt = 16'h00c8;
      hpw = 16'h0123;
      rlong = 32'h0000_0064;
      rlat = 32'hffff_fff0;
      vel = 32'h00ab_cdef;
      pk = 32'h0000_0200;
      ax = 16'h8001;
      ay = 16'h0010;
      az = 16'h03e8;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      t_codes();
      t_measured();
      t_address();
      t_zero_factory();
      wrap_up();
   end
   // cuts a hang short well beyond the expected few hundred cycles
   initial begin
      #200000;
      err_total++;
      wrap_up();
   end
endmodule
